// ---- core/udf_port_core.sv ----
// port logic of the usb digital i/o and fet output block, ahb-lite slave
// How it works
// - direction mask bit one makes port output
// - high-impedance flag true floats every I/O line
// - high-impedance change applied after mask and data
// - all lines high-impedance after reset
// - output values loaded before lines leave high-impedance
// - configure drops data for input ports
// - write-all copies bytes, skips input ports
// - read-all samples each port into its byte
// - image nine bytes, mask one byte
// - bytes 0-5 ttl, bytes 6-8 fet
// - absent variant positions stay unused
// - lamp steady once host configured device
// - lamp flashes during link transfers
// - fet outputs off from power-up
// - fet outputs hold state after link loss
//
// The implementer's own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module udf_port_core #(
    parameter int unsigned BLINK_CYCLES = udf_pkg::LAMP_HALF_CYCLES // lamp half period in clocks
) (
    input wire logic clk,            // system clock, 100 MHz
    input wire logic rst_b,          // async reset, active low
    input wire logic hsel,           // ahb slave select
    input wire logic [31:0] haddr,   // ahb address
    input wire logic [1:0] htrans,   // ahb transfer type
    input wire logic hwrite,         // ahb write
    input wire logic [2:0] hsize,    // ahb size, only word honoured
    input wire logic [31:0] hwdata,  // ahb write data
    input wire logic hready,         // ahb bus ready
    output logic [31:0] hrdata,      // ahb read data
    output logic hreadyout,          // ahb slave ready
    output logic hresp,              // ahb response, always okay
    input wire logic [47:0] ttlIn,   // ttl line levels
    output logic [47:0] ttlOut,      // ttl line drive values
    output logic [47:0] ttlOe,       // ttl line drive enables
    output logic [23:0] fetOut,      // fet switch commands, high is on
    output logic lampOut             // status lamp
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    udf_pkg::udf_req_t req;
    udf_pkg::udf_state_t state;
    udf_pkg::udf_state_t next_state;
    udf_pkg::udf_op_t op;
    logic [7:0] dirStage;
    logic [71:0] stageFlat;
    logic [71:0] readFlat;
    logic [7:0] dirMask;
    logic hiz;
    logic pendHiz;
    logic linkUp;
    logic traffic;
    udf_pkg::udf_image_t stageView;

    assign stageView = udf_pkg::udf_image_t'(stageFlat);

    // ------------------------------------------------------------
    // ahb decode
    // ------------------------------------------------------------
    wire addrPhase = hsel & htrans[1] & hready;
    wire wordSize = (hsize == 3'h2);
    wire wrPhase = req.valid & req.write;
    wire wrCmd = wrPhase & (req.addr == udf_pkg::ADDR_CMD);
    wire wrDir = wrPhase & (req.addr == udf_pkg::ADDR_DIR);
    wire wrImg0 = wrPhase & (req.addr == udf_pkg::ADDR_IMG0);
    wire wrImg1 = wrPhase & (req.addr == udf_pkg::ADDR_IMG1);
    wire wrImg2 = wrPhase & (req.addr == udf_pkg::ADDR_IMG2);
    wire wrLink = wrPhase & (req.addr == udf_pkg::ADDR_LINK);
    wire busy = (state != udf_pkg::UDF_IDLE);
    // a command written while busy is dropped; software polls busy first
    wire go = wrCmd & ~busy & (hwdata[1:0] != udf_pkg::UDF_OP_NONE);

    wire [31:0] statusWord = {16'h0000, dirMask, 5'h00, linkUp, hiz, busy};
    wire [31:0] rdSel =
        (haddr == udf_pkg::ADDR_DIR) ? {24'h00_0000, dirStage} :
        (haddr == udf_pkg::ADDR_IMG0) ? stageFlat[31:0] :
        (haddr == udf_pkg::ADDR_IMG1) ? stageFlat[63:32] :
        (haddr == udf_pkg::ADDR_IMG2) ? {24'h00_0000, stageFlat[71:64]} :
        (haddr == udf_pkg::ADDR_RD0) ? readFlat[31:0] :
        (haddr == udf_pkg::ADDR_RD1) ? readFlat[63:32] :
        (haddr == udf_pkg::ADDR_RD2) ? {24'h00_0000, readFlat[71:64]} :
        (haddr == udf_pkg::ADDR_STATUS) ? statusWord :
        (haddr == udf_pkg::ADDR_LINK) ? {31'h0000_0000, linkUp} :
        32'h0000_0000;

    // zero wait states: the answer is latched at the end of the address phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req <= '0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            req <= '{addr: haddr, write: hwrite, valid: addrPhase & wordSize};
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addrPhase && !hwrite) begin
                hrdata <= wordSize ? rdSel : 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // staging registers written by software
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dirStage <= udf_pkg::RST_DIR;
            stageFlat <= 72'h00_0000_0000_0000_0000;
            linkUp <= 1'b0;
        end else begin
            if (wrDir) begin
                dirStage <= hwdata[7:0];
            end
            if (wrImg0) begin
                stageFlat[31:0] <= hwdata;
            end
            if (wrImg1) begin
                stageFlat[63:32] <= hwdata;
            end
            if (wrImg2) begin
                stageFlat[71:64] <= hwdata[7:0];
            end
            if (wrLink) begin
                linkUp <= hwdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            udf_pkg::UDF_IDLE: begin
                if (go) begin
                    next_state = (hwdata[1:0] == udf_pkg::UDF_OP_READ_ALL) ?
                        udf_pkg::UDF_SAMPLE : udf_pkg::UDF_LOAD;
                end
            end
            udf_pkg::UDF_LOAD: begin
                next_state = (op == udf_pkg::UDF_OP_CONFIG) ? udf_pkg::UDF_HIZ : udf_pkg::UDF_IDLE;
            end
            udf_pkg::UDF_HIZ: begin
                next_state = udf_pkg::UDF_IDLE;
            end
            udf_pkg::UDF_SAMPLE: begin
                next_state = udf_pkg::UDF_IDLE;
            end
            default: begin
                next_state = udf_pkg::UDF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= udf_pkg::UDF_IDLE;
            op <= udf_pkg::UDF_OP_NONE;
            pendHiz <= udf_pkg::RST_HIZ;
        end else begin
            state <= next_state;
            if (go) begin
                op <= udf_pkg::udf_op_t'(hwdata[1:0]);
                pendHiz <= hwdata[udf_pkg::CMD_HIZ_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------
    // configure uses the mask it carries, write-all the mask in force
    wire [7:0] loadMask = (op == udf_pkg::UDF_OP_CONFIG) ? dirStage : dirMask;
    wire [47:0] loadLines = udf_pkg::udf_expand(loadMask[5:0] & udf_pkg::TTL_PORT_PRESENT);
    wire [47:0] activeLines = udf_pkg::udf_expand(dirMask[5:0] & udf_pkg::TTL_PORT_PRESENT);
    wire [47:0] ttlNew = stageView.ttl;
    wire [23:0] fetNew = stageView.fet;
    wire inLoad = (state == udf_pkg::UDF_LOAD);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dirMask <= udf_pkg::RST_DIR;
            hiz <= udf_pkg::RST_HIZ;
            ttlOut <= udf_pkg::RST_TTL;
            fetOut <= udf_pkg::RST_FET;
        end else begin
            if (inLoad && op == udf_pkg::UDF_OP_CONFIG) begin
                dirMask <= dirStage;
            end
            if (inLoad) begin
                // bytes of input ports leave the old value untouched
                ttlOut <= (ttlNew & loadLines) | (ttlOut & ~loadLines);
                fetOut <= fetNew & udf_pkg::FET_LINE_PRESENT;
            end
            // fets are never cleared when the link drops, only by reset or by a command load
            if (state == udf_pkg::UDF_HIZ) begin
                hiz <= pendHiz;
            end
        end
    end

    // enables follow mask and float flag one clock later, so the drive value
    // is already settled when a line starts to drive
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ttlOe <= 48'h0000_0000_0000;
        end else begin
            ttlOe <= activeLines & {48{~hiz}};
        end
    end

    // ------------------------------------------------------------
    // read-all capture
    // ------------------------------------------------------------
    wire [47:0] ttlPresent = udf_pkg::udf_expand(udf_pkg::TTL_PORT_PRESENT);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            readFlat <= 72'h00_0000_0000_0000_0000;
        end else if (state == udf_pkg::UDF_SAMPLE) begin
            readFlat <= {fetOut, ttlIn & ttlPresent};
        end
    end

    // ------------------------------------------------------------
    // status lamp
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            traffic <= 1'b0;
        end else begin
            traffic <= go;
        end
    end

    udf_status_lamp #(
        .BLINK_CYCLES(BLINK_CYCLES)
    ) u_lamp (
        .clk(clk),
        .rst_b(rst_b),
        .linkUp(linkUp),
        .traffic(traffic),
        .lamp(lampOut)
    );

endmodule

// ---- core/udf_pkg.sv ----
// shared constants, types and helpers of the usb port i/o block
package udf_pkg;

    // ------------------------------------------------------------
    // port geometry
    // ------------------------------------------------------------
    localparam int TTL_PORTS = 6;
    localparam int FET_PORTS = 3;
    localparam int IMAGE_BYTES = 9;
    localparam int TTL_LINES = 48;
    localparam int FET_LINES = 24;
    // positions that a smaller variant leaves unused are cleared here
    localparam logic [5:0] TTL_PORT_PRESENT = 6'h3F;
    localparam logic [23:0] FET_LINE_PRESENT = 24'hFF_FFFF;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_CMD = 32'h0000_0000;
    localparam logic [31:0] ADDR_DIR = 32'h0000_0004;
    localparam logic [31:0] ADDR_IMG0 = 32'h0000_0008;
    localparam logic [31:0] ADDR_IMG1 = 32'h0000_000C;
    localparam logic [31:0] ADDR_IMG2 = 32'h0000_0010;
    localparam logic [31:0] ADDR_RD0 = 32'h0000_0014;
    localparam logic [31:0] ADDR_RD1 = 32'h0000_0018;
    localparam logic [31:0] ADDR_RD2 = 32'h0000_001C;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0020;
    localparam logic [31:0] ADDR_LINK = 32'h0000_0024;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CMD_HIZ_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_HIZ_BIT = 1;
    localparam int STAT_LINK_BIT = 2;
    localparam int STAT_DIR_LSB = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_HIZ = 1'b1;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [23:0] RST_FET = 24'h00_0000;
    localparam logic [47:0] RST_TTL = 48'h0000_0000_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int LAMP_HALF_PERIOD_US = 50000;
    localparam int LAMP_HALF_CYCLES = LAMP_HALF_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam logic [3:0] LAMP_ACT_TICKS = 4'h8;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UDF_OP_NONE = 2'h0,
        UDF_OP_CONFIG = 2'h1,
        UDF_OP_WRITE_ALL = 2'h2,
        UDF_OP_READ_ALL = 2'h3
    } udf_op_t;

    typedef enum logic [1:0] {
        UDF_IDLE = 2'h0,
        UDF_LOAD = 2'h1,
        UDF_HIZ = 2'h3,
        UDF_SAMPLE = 2'h2
    } udf_state_t;

    // byte 0 sits in the low bits: ttl ports first, fet ports last
    typedef struct packed {
        logic [FET_PORTS-1:0][7:0] fet;
        logic [TTL_PORTS-1:0][7:0] ttl;
    } udf_image_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic valid;
    } udf_req_t;

    // one bit per port widened to one bit per line, bit n to lines 8n to 8n+7
    function automatic logic [47:0] udf_expand(input logic [5:0] portMask);
        logic [47:0] lines;
        lines = 48'h0000_0000_0000;
        for (int p = 0; p < TTL_PORTS; p++) begin
            lines[8*p +: 8] = {8{portMask[p]}};
        end
        return lines;
    endfunction

endpackage

// ---- core/udf_status_lamp.sv ----
// status lamp driver: steady when enumerated, blinking while traffic flows
`timescale 1ns/1ps
module udf_status_lamp #(
    parameter int unsigned BLINK_CYCLES = udf_pkg::LAMP_HALF_CYCLES // half blink period in clocks
) (
    input wire logic clk,     // system clock
    input wire logic rst_b,   // async reset, active low
    input wire logic linkUp,  // host has enumerated and configured us
    input wire logic traffic, // one-cycle pulse per transaction
    output logic lamp         // lamp drive, high is lit
);

    // ------------------------------------------------------------
    // blink rate divider
    // ------------------------------------------------------------
    logic [31:0] divCnt;
    logic [3:0] actLeft;
    logic blink;
    wire tick = (divCnt == BLINK_CYCLES - 32'h0000_0001);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= 32'h0000_0000;
        end else begin
            divCnt <= tick ? 32'h0000_0000 : divCnt + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // activity window and lamp
    // ------------------------------------------------------------
    // a new transaction reloads the window even on a tick, so none is lost
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            actLeft <= 4'h0;
        end else if (traffic) begin
            actLeft <= udf_pkg::LAMP_ACT_TICKS;
        end else if (tick && actLeft != 4'h0) begin
            actLeft <= actLeft - 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blink <= 1'b0;
        end else if (tick) begin
            blink <= ~blink;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lamp <= 1'b0;
        end else begin
            lamp <= linkUp & ((actLeft == 4'h0) | blink);
        end
    end

endmodule

// ---- sim/udf_port_assertions.sv ----
// pin-level checks of the port core, bound to every instance
`timescale 1ns/1ps
module udf_port_assertions (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic hsel, // ahb select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb ready
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [47:0] ttlIn, // line levels
    input wire logic [47:0] ttlOut, // drive values
    input wire logic [47:0] ttlOe, // drive enables
    input wire logic [23:0] fetOut, // fet commands
    input wire logic lampOut // lamp
);
    // --------
    // command tracking
    // --------
    logic cmdPhase;
    wire cmdTake = hsel & htrans[1] & hwrite & hready & (haddr == udf_pkg::ADDR_CMD) & (hsize == 3'h2);
    wire cfgHit = cmdPhase & (hwdata[1:0] == 2'h1);
    wire wrHit = cmdPhase & ((hwdata[1:0] == 2'h1) | (hwdata[1:0] == 2'h2));
    wire [5:0] portMixed;
    for (genvar p = 0; p < 6; p++) begin : g_port
        assign portMixed[p] = (ttlOe[8*p +: 8] != 8'h00) & (ttlOe[8*p +: 8] != 8'hFF);
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdPhase <= 1'b0;
        end else begin
            cmdPhase <= cmdTake;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // --------
    // properties
    // --------
    a_port_uniform: assert property (portMixed == 6'h00)
        else $error("ttl enables split inside a port");
    a_hiz_reset: assert property ($rose(rst_b) |-> ttlOe == 48'h0000_0000_0000)
        else $error("ttl lines driven after reset");
    a_fet_reset: assert property ($rose(rst_b) |-> fetOut == 24'h00_0000)
        else $error("fet on after reset");
    a_lamp_reset: assert property ($rose(rst_b) |-> !lampOut)
        else $error("lamp lit before configuration");
    // enables move only three and four edges after a configure lands
    a_oe_after_cfg: assert property (!$stable(ttlOe) |-> $past(cfgHit, 3) || $past(cfgHit, 4))
        else $error("ttl enables changed outside configure");
    a_out_before_oe: assert property ((|(ttlOe & ~$past(ttlOe))) |-> $stable(ttlOut))
        else $error("drive value moved as line left hiz");
    a_fet_hold: assert property (!$stable(fetOut) |-> $past(wrHit, 2))
        else $error("fet outputs changed without command");
    a_ttl_load: assert property (!$stable(ttlOut) |-> $past(wrHit, 2))
        else $error("ttl drive changed without command");
endmodule
bind udf_port_core udf_port_assertions u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ttlIn(ttlIn), .ttlOut(ttlOut), .ttlOe(ttlOe),
    .fetOut(fetOut), .lampOut(lampOut));

// ---- sim/udf_field_model.sv ----
// field wiring on the ttl lines: pull-ups plus an external driver
`timescale 1ns/1ps
module udf_field_model (
    input wire logic [47:0] ttlOut, // core drive values
    input wire logic [47:0] ttlOe, // core drive enables
    input wire logic [47:0] extVal, // external driver levels
    input wire logic [47:0] extEn, // external driver enables
    output logic [47:0] ttlIn // resolved line levels
);
    // a floating line reads the pull-up level, never a stale value
    assign ttlIn = (ttlOe & ttlOut) | (~ttlOe & extEn & extVal) | (~ttlOe & ~extEn);
endmodule

// ---- sim/udf_port_core_tb.sv ----
// self-checking bench for the usb port i/o core
`timescale 1ns/1ps
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin miscompares++; \
$display("[FAIL] %s exp %h got %h", n, e, g); end end
module udf_port_core_tb;
    logic clk, rst_b, hsel, hwrite, hreadyout, hresp, lampOut;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [47:0] ttlIn, ttlOut, ttlOe, extVal, extEn, expOut, expOe, pin;
    logic [23:0] fetOut;
    logic [71:0] exp72;
    logic [7:0] mask;
    udf_pkg::udf_image_t img;
    int miscompares = 0;
    int checksDone = 0;
    int cycles = 0;
    int flips;
    logic lampPrev;
    udf_port_core #(.BLINK_CYCLES(4)) uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ttlIn(ttlIn), .ttlOut(ttlOut),
        .ttlOe(ttlOe), .fetOut(fetOut), .lampOut(lampOut));
    udf_field_model field (.ttlOut(ttlOut), .ttlOe(ttlOe), .extVal(extVal), .extEn(extEn), .ttlIn(ttlIn));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // --------
    // bus and check tasks
    // --------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        `CHK("hresp", 1'b0, hresp)
    endtask
    // the core needs a few edges after a command; the bench never overlaps two
    task automatic cmd(input logic [31:0] c);
        bus(1'b1, udf_pkg::ADDR_DIR, {24'h00_0000, mask}, rd);
        bus(1'b1, udf_pkg::ADDR_IMG0, img[31:0], rd);
        bus(1'b1, udf_pkg::ADDR_IMG1, img[63:32], rd);
        bus(1'b1, udf_pkg::ADDR_IMG2, {24'h00_0000, img[71:64]}, rd);
        bus(1'b1, udf_pkg::ADDR_CMD, c, rd);
        repeat (5) @(posedge clk);
    endtask
    task automatic lines(input logic hiz);
        for (int p = 0; p < 6; p++) begin
            if (mask[p]) expOut[8*p +: 8] = img.ttl[p];
            expOe[8*p +: 8] = {8{mask[p] & ~hiz}};
        end
        `CHK("ttlOut", expOut, ttlOut)
        `CHK("ttlOe", expOe, ttlOe)
        `CHK("fetOut", img.fet, fetOut)
    endtask
    // --------
    // scenarios
    // --------
    initial begin
        rst_b = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        extVal = 48'hA5C3_0F96_5AE1;
        extEn = 48'hFFFF_FFFF_FFFF;
        expOut = 48'h0000_0000_0000;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        `CHK("ttlOe", 48'h0000_0000_0000, ttlOe)
        `CHK("fetOut", 24'h00_0000, fetOut)
        bus(1'b0, udf_pkg::ADDR_STATUS, 32'h0000_0000, rd);
        `CHK("status", 32'h0000_0002, rd)
        bus(1'b0, 32'h0000_0040, 32'h0000_0000, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        mask = 8'h05;
        img = 72'h99_8877_6655_4433_2211;
        cmd(32'h0000_0001);
        lines(1'b0);
        bus(1'b0, udf_pkg::ADDR_STATUS, 32'h0000_0000, rd);
        `CHK("status", 32'h0000_0500, rd)
        mask = 8'hFA;
        img = 72'h5A_C3E7_1824_BD42_7E81;
        cmd(32'h0000_0011);
        lines(1'b1);
        img = 72'h0F_F00F_F0A5_5AA5_5A3C;
        cmd(32'h0000_0002);
        lines(1'b1);
        mask = 8'h0C;
        cmd(32'h0000_0001);
        lines(1'b0);
        extVal <= 48'h9D2E_61B7_C458;
        cmd(32'h0000_0003);
        pin = (expOe & expOut) | (~expOe & 48'h9D2E_61B7_C458);
        exp72 = {img.fet, pin};
        bus(1'b0, udf_pkg::ADDR_RD0, 32'h0000_0000, rd);
        `CHK("rd0", exp72[31:0], rd)
        bus(1'b0, udf_pkg::ADDR_RD1, 32'h0000_0000, rd);
        `CHK("rd1", exp72[63:32], rd)
        bus(1'b0, udf_pkg::ADDR_RD2, 32'h0000_0000, rd);
        `CHK("rd2", {24'h00_0000, exp72[71:64]}, rd)
        bus(1'b1, udf_pkg::ADDR_LINK, 32'h0000_0001, rd);
        repeat (60) @(posedge clk);
        `CHK("lampSteady", 1'b1, lampOut)
        cmd(32'h0000_0003);
        flips = 0;
        lampPrev = lampOut;
        repeat (24) begin
            @(posedge clk);
            if (lampPrev !== lampOut) flips++;
            lampPrev = lampOut;
        end
        `CHK("lampFlips", 1'b1, flips > 2)
        bus(1'b1, udf_pkg::ADDR_LINK, 32'h0000_0000, rd);
        repeat (3) @(posedge clk);
        `CHK("lampOff", 1'b0, lampOut)
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        `CHK("ttlOe", 48'h0000_0000_0000, ttlOe)
        `CHK("fetOut", 24'h00_0000, fetOut)
        conclude();
    end
endmodule
